// ---- rtl/config_write_lock_keys.sv ----
// Write-protected configuration register bank with key unlock
// Function
// - Lock engaged after power-on reset
// - Locked: writes dropped, reads still served
// - First key then second key unlocks
// - Unlocked: writable registers accept, read-only ignore
// - Value matching neither key, written to a key, relocks
// - One lock shared by every core
`include "config_lock_params.svh"
module config_write_lock_keys
   import config_lock_pkg::*;
#(
   parameter int NUM_REGS   = 8,
   parameter int ADDR_WIDTH = 8,
   parameter logic [NUM_REGS-1:0] READ_ONLY_MASK = '0
)
(
   // Clock and reset
   input  wire logic                      mclk,
   input  wire logic                      srst,
   // Configuration bus from all cores
   input  wire logic                      busWrite,
   input  wire logic                      busRead,
   input  wire logic [ADDR_WIDTH-1:0]     busAddr,
   input  wire logic [31:0]               busWriteData,
   output logic      [31:0]               busReadData,
   output logic                           busReadValid,
   output logic                           writeDropped,
   // Read-only inputs and register contents
   input  wire logic [NUM_REGS*32-1:0]    readOnlyValue,
   output logic      [NUM_REGS*32-1:0]    cfgValue,
   // Lock status
   output logic                           locked
);
   import config_lock_pkg::*;

   // Elaboration checks: both keys and the bank share one index space
   generate
      if (NUM_REGS < 1)
      begin : g_badCount
         $error("config_write_lock_keys: NUM_REGS must be at least one");
      end
      if (ADDR_WIDTH < 2 || ADDR_WIDTH > 16)
      begin : g_badWidth
         $error("config_write_lock_keys: ADDR_WIDTH must be 2 to 16");
      end
      if (NUM_REGS + `CFG_FIRST_INDEX > (1 << ADDR_WIDTH))
      begin : g_badFit
         $error("config_write_lock_keys: NUM_REGS does not fit address space");
      end
   endgenerate

   // Lock state and key decode
   lock_state_t         lockState;
   logic                keyFirstHit;
   logic                keySecondHit;
   logic                keyFirstWrite;
   logic                keySecondWrite;
   logic                keyHit;
   logic                isUnlocked;
   // Register bank
   logic [31:0]         cfgReg [NUM_REGS];
   logic [NUM_REGS-1:0] regHit;
   logic [NUM_REGS-1:0] regWrite;
   logic                anyHit;
   logic                anyStored;
   // Read and drop decisions
   logic [31:0]         next_readData;
   logic [31:0]         readAnswer;
   logic                cfgWriteReq;
   logic                dropNow;

   // Key register decode; a key write never touches the bank
   assign keyFirstHit    = (busAddr == ADDR_WIDTH'(`KEY_FIRST_INDEX));
   assign keySecondHit   = (busAddr == ADDR_WIDTH'(`KEY_SECOND_INDEX));
   assign keyHit         = keyFirstHit || keySecondHit;
   assign keyFirstWrite  = busWrite && keyFirstHit;
   assign keySecondWrite = busWrite && keySecondHit;

   // Half-open still counts as locked for the bank
   assign isUnlocked = (lockState == OPEN);
   assign locked     = !isUnlocked;

   // Single lock instance serves every core
   lock_keeper keeper
   (
      .mclk           (mclk),
      .srst           (srst),
      .keyFirstWrite  (keyFirstWrite),
      .keySecondWrite (keySecondWrite),
      .keyData        (busWriteData),
      .lockState      (lockState)
   );

   // Per-register decode and write gating
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++)
      begin : regs
         assign regHit[g]   = (busAddr == ADDR_WIDTH'(`CFG_FIRST_INDEX) + ADDR_WIDTH'(g));
         // Locked drops writes; read-only never stored
         assign regWrite[g] = busWrite && regHit[g] && isUnlocked
                              && !READ_ONLY_MASK[g];
         always_ff @(posedge mclk)
         begin
            if (srst)
               cfgReg[g] <= 32'h0000_0000;
            else if (regWrite[g])
               cfgReg[g] <= busWriteData;
         end
         assign cfgValue[g*32 +: 32] = READ_ONLY_MASK[g] ? readOnlyValue[g*32 +: 32]
                                                         : cfgReg[g];
      end
   endgenerate

   // Bank hit and store summaries
   assign anyHit    = |regHit;
   assign anyStored = |regWrite;

   // Read mux; keys read back as zero to hide the values
   always_comb
   begin
      next_readData = 32'h0000_0000;
      for (int i = 0; i < NUM_REGS; i++)
      begin
         if (regHit[i])
            next_readData = cfgValue[i*32 +: 32];
      end
   end

   // Answer and drop decisions; a bank write that stored nothing was refused
   assign readAnswer  = busRead ? next_readData : 32'h0000_0000;
   assign cfgWriteReq = busWrite && anyHit && !keyHit;
   assign dropNow     = cfgWriteReq && !anyStored;

   // Read data, registered so every core sees one cycle of latency
   always_ff @(posedge mclk)
   begin
      if (srst)
         busReadData <= 32'h0000_0000;
      else
         busReadData <= readAnswer;
   end

   // Read valid pulse, one cycle after the request
   always_ff @(posedge mclk)
   begin
      if (srst)
         busReadValid <= 1'b0;
      else
         busReadValid <= busRead;
   end

   // Dropped-write pulse, lets software spot a store made while locked
   always_ff @(posedge mclk)
   begin
      if (srst)
         writeDropped <= 1'b0;
      else
         writeDropped <= dropNow;
   end
endmodule

// ---- rtl/config_lock_params.svh ----
// Constants for the configuration write lock
`ifndef CONFIG_LOCK_PARAMS_SVH
`define CONFIG_LOCK_PARAMS_SVH
`define KEY_FIRST_VALUE   32'h83E70B13
`define KEY_SECOND_VALUE  32'h95A4F1E0
`define KEY_FIRST_INDEX   8'h00
`define KEY_SECOND_INDEX  8'h01
`define CFG_FIRST_INDEX   8'h02
`define LOCK_RESET_STATE  1'b1
`endif

// ---- rtl/config_lock_pkg.sv ----
// Types for the configuration write lock
package config_lock_pkg;
   typedef enum logic [1:0]
   {
      LOCKED    = 2'b00,
      HALF_OPEN = 2'b01,
      OPEN      = 2'b10
   } lock_state_t;
endpackage

// ---- rtl/lock_keeper.sv ----
// Key sequence tracker that holds the shared lock state
`include "config_lock_params.svh"
module lock_keeper
   import config_lock_pkg::*;
(
   // Clock and reset
   input  wire logic                      mclk,
   input  wire logic                      srst,
   // Key register writes
   input  wire logic                      keyFirstWrite,
   input  wire logic                      keySecondWrite,
   input  wire logic [31:0]               keyData,
   // Lock state
   output config_lock_pkg::lock_state_t   lockState
);
   import config_lock_pkg::*;

   lock_state_t next_lockState;
   logic        firstMatch;
   logic        secondMatch;

   // Key comparisons
   assign firstMatch  = (keyData == `KEY_FIRST_VALUE);
   assign secondMatch = (keyData == `KEY_SECOND_VALUE);

   // Next state of the ordered unlock sequence
   always_comb
   begin
      next_lockState = lockState;
      case (lockState)
         LOCKED:
         begin
            if (keyFirstWrite && firstMatch)
               next_lockState = HALF_OPEN;
         end
         HALF_OPEN:
         begin
            if (keySecondWrite)
               next_lockState = secondMatch ? OPEN : LOCKED;
            else if (keyFirstWrite && !firstMatch)
               next_lockState = LOCKED;
         end
         OPEN:
         begin
            // A value matching neither key, written to either key, relocks
            if ((keyFirstWrite && !firstMatch && !secondMatch) ||
                (keySecondWrite && !firstMatch && !secondMatch))
               next_lockState = LOCKED;
         end
         default:
            next_lockState = LOCKED;
      endcase
   end

   // One lock for all cores; starts engaged
   always_ff @(posedge mclk)
   begin
      if (srst)
         lockState <= LOCKED;
      else
         lockState <= next_lockState;
   end
endmodule

// ---- bench/cfg_core.sv ----
// Core-side master model for the configuration bus
module cfg_core
(
   // Bus toward the lock bank
   input  wire logic   mclk,
   output logic [1:0]  busStrobe,
   output logic [7:0]  busAddr,
   output logic [31:0] busWriteData
);
   timeunit 1ns / 1ns;
   initial {busStrobe, busAddr, busWriteData} = '0;
   // One strobe cycle, then idle lines flip so stale data never looks valid
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(negedge mclk);
      {busStrobe, busAddr, busWriteData} = {w, !w, a, d};
      @(negedge mclk);
      {busStrobe, busAddr, busWriteData} = {2'b00, ~a, ~d};
   endtask
endmodule

// ---- bench/config_lock_asserts.sv ----
// Port checks for the configuration write lock
module config_lock_asserts
(
   // Watched ports
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic        busWrite,
   input wire logic        busRead,
   input wire logic        busReadValid,
   input wire logic [7:0]  busAddr,
   input wire logic [31:0] busWriteData,
   input wire logic        writeDropped,
   input wire logic        locked
);
   timeunit 1ns / 1ns;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (srst);
   // Ordered key pair with one idle cycle between
   sequence s_keys;
      busWrite && busAddr == 8'h00 && busWriteData == 32'h83E70B13 ##1 !busWrite
      ##1 busWrite && busAddr == 8'h01 && busWriteData == 32'h95A4F1E0;
   endsequence
   property p_rst; $fell(srst) |-> locked; endproperty
   a_rst: assert property (p_rst) else $error("open after reset");
   property p_drop; locked && busWrite && busAddr == 8'h02 |=> writeDropped; endproperty
   a_drop: assert property (p_drop) else $error("locked write kept");
   property p_open; s_keys |=> !locked; endproperty
   a_open: assert property (p_open) else $error("keys did not unlock");
   property p_relock; busWrite && busAddr < 8'h02 && !busWriteData[31] |=> locked; endproperty
   a_relock: assert property (p_relock) else $error("stray key left it open");
   property p_rdv; busRead |=> busReadValid; endproperty
   a_rdv: assert property (p_rdv) else $error("read not answered");
   property p_store; !locked && busWrite && busAddr == 8'h02 |=> !writeDropped; endproperty
   a_store: assert property (p_store) else $error("open write dropped");
endmodule
bind config_write_lock_keys config_lock_asserts i_config_lock_asserts (.mclk(mclk),
   .srst(srst), .busWrite(busWrite), .busRead(busRead), .busReadValid(busReadValid),
   .busAddr(busAddr), .busWriteData(busWriteData),
   .writeDropped(writeDropped), .locked(locked));

// ---- bench/tb.sv ----
// Self-checking bench for the configuration write lock
module tb;
   timeunit 1ns / 1ns;
   logic         mclk = 0, srst = 1, wr, rd, rdValid, dropped, locked;
   logic [7:0]   addr;
   logic [1:0]   strobe;
   logic [31:0]  wData, rData;
   logic [255:0] cfgValue;
   int           err_total = 0, checks_done = 0;
   // Register 1 is read-only with a fixed pattern
   config_write_lock_keys #(.READ_ONLY_MASK(8'h02)) i_config_write_lock_keys (.mclk(mclk),
      .srst(srst), .busWrite(wr), .busRead(rd), .busAddr(addr), .busWriteData(wData),
      .busReadData(rData), .busReadValid(rdValid), .writeDropped(dropped),
      .readOnlyValue({8{32'hA5A50F0F}}), .cfgValue(cfgValue), .locked(locked));
   assign {wr, rd} = strobe;
   cfg_core i_cfg_core (.mclk(mclk), .busStrobe(strobe), .busAddr(addr), .busWriteData(wData));
   // 40 ns clock
   initial forever #20 mclk = ~mclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      err_total += int'(got !== exp);
      if (got !== exp) $display("MISMATCH %0t got %h exp %h", $time, got, exp);
   endtask
   task automatic finish_test(input int extra);
      err_total += extra;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Locked: store refused, read served, lone second key ignored
   task automatic t_locked();
      chk(locked, 1);
      i_cfg_core.acc(1, 8'h02, 32'h12345678);
      i_cfg_core.acc(0, 8'h02, 32'h0);
      chk({rdValid, rData[30:0]}, 32'h80000000);
      i_cfg_core.acc(1, 8'h01, 32'h95A4F1E0);
      chk(locked, 1);
   endtask
   // Open: store lands, read-only refuses, stray key relocks
   task automatic t_open();
      i_cfg_core.acc(1, 8'h00, 32'h83E70B13);
      i_cfg_core.acc(1, 8'h01, 32'h95A4F1E0);
      i_cfg_core.acc(1, 8'h02, 32'hC0DE0001);
      chk(cfgValue[31:0], 32'hC0DE0001);
      i_cfg_core.acc(0, 8'h02, 32'h0);
      chk(rData, 32'hC0DE0001);
      i_cfg_core.acc(1, 8'h03, 32'h55555555);
      chk({dropped, cfgValue[62:32]}, 32'hA5A50F0F);
      i_cfg_core.acc(1, 8'h00, 32'h00000001);
      i_cfg_core.acc(1, 8'h02, 32'hFFFFFFFF);
      chk(cfgValue[31:0], 32'hC0DE0001);
   endtask
   // Reset for 12 cycles, then the scenarios
   initial
   begin
      repeat (12) @(negedge mclk);
      srst = 0;
      t_locked();
      t_open();
      finish_test(0);
   end
   // Watchdog: the run needs about 32 cycles
   initial #20000 finish_test(1);
endmodule
